// >>> design/fsp_spi_mem.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
module fsp_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic in_valid_in,
   input wire logic [W-1:0] in_data_in,
   output logic in_ready_out,
   output logic out_valid_out,
   output logic [W-1:0] out_data_out,
   input wire logic out_ready_in
);
   localparam int PW = $clog2(DEPTH);
   logic [W-1:0] mem_q [DEPTH];
   logic [PW-1:0] wp_q;
   logic [PW-1:0] rp_q;
   logic [PW:0] cnt_q;
   logic push;
   logic pop;

   assign in_ready_out = cnt_q != (PW+1)'(DEPTH);
   assign out_valid_out = cnt_q != '0;
   assign out_data_out = mem_q[rp_q];
   assign push = in_valid_in & in_ready_out;
   assign pop = out_valid_out & out_ready_in;

   always_ff @(posedge clk_in)
   begin
      if (push)
      begin
         mem_q[wp_q] <= in_data_in;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         wp_q <= push ? wp_q + PW'(1) : wp_q;
         rp_q <= pop ? rp_q + PW'(1) : rp_q;
         cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////
module fsp_spi_mem (
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic cs_n_in,
   input wire logic sck_in,
   input wire logic si_in,
   input wire logic write_guard_pin_n_in,
   output logic so_out,
   output logic so_oe_out,
   output logic [fsp_pkg::DATA_W-1:0] protection_status_out
);
   import fsp_pkg::*;

   logic [PIN_N-1:0] pin_raw;
   logic [SYNC_N-1:0] sync_q [PIN_N];
   logic [PIN_N-1:0] lvl_q;
   logic [PIN_N-1:0] prv_q;
   logic cs_fall;
   logic cs_rise;
   logic sel;
   logic rise;
   logic fall_act;
   logic byte_done;
   logic [7:0] rx;
   logic sr_blocked;
   logic cur_guarded;
   logic shifting;
   logic [7:0] status;

   fsp_state_e state_q;
   fsp_state_e state_d;
   logic [7:0] op_q;
   logic [7:0] op_d;
   logic [ADDR_W-1:0] addr_q;
   logic [ADDR_W-1:0] addr_d;
   logic stop_q;
   logic stop_d;
   logic pend_q;
   logic pend_d;
   logic [2:0] cnt_q;
   logic [7:0] sh_q;
   logic mode3_q;
   logic rise_seen_q;
   logic wel_q;
   logic lock_q = 1'b0;
   logic bphi_q = 1'b0;
   logic bplo_q = 1'b0;
   logic [7:0] tx_q;
   logic so_q;
   logic rd_req_q;
   logic rd_req_d;
   logic rd_load_q;
   logic [7:0] rdata_q;
   logic [7:0] arr_q [2**ADDR_W];
   logic wel_set;
   logic sr_load;
   logic push_req;
   logic tx_load_sr;
   fsp_wr_s pw_q;
   logic pw_valid_q;
   logic fifo_in_ready;
   logic fifo_valid;
   fsp_wr_s fifo_out;
   logic fifo_pop;

   ////////////////////////////////////////////////////////////////////
   // pin sampling, three stages, level moves when stages 2 and 3 agree
   assign pin_raw = {write_guard_pin_n_in, si_in, sck_in, cs_n_in};

   for (genvar gi = 0; gi < PIN_N; gi++)
   begin : g_sync
      always_ff @(posedge mclk_in)
      begin
         if (rst_in)
         begin
            sync_q[gi] <= {SYNC_N{PIN_RST[gi]}};
            lvl_q[gi] <= PIN_RST[gi];
            prv_q[gi] <= PIN_RST[gi];
         end
         else
         begin
            sync_q[gi] <= {sync_q[gi][SYNC_N-2:0], pin_raw[gi]};
            if (sync_q[gi][1] == sync_q[gi][2])
            begin
               lvl_q[gi] <= sync_q[gi][2];
            end
            prv_q[gi] <= lvl_q[gi];
         end
      end
   end

   assign cs_fall = prv_q[PIN_CS] & ~lvl_q[PIN_CS];
   assign cs_rise = ~prv_q[PIN_CS] & lvl_q[PIN_CS];
   assign sel = ~lvl_q[PIN_CS];
   assign rise = sel & ~prv_q[PIN_SCK] & lvl_q[PIN_SCK];
   assign fall_act = sel & prv_q[PIN_SCK] & ~lvl_q[PIN_SCK]
                     & (rise_seen_q | ~mode3_q);
   assign rx = {sh_q[6:0], lvl_q[PIN_SI]};
   assign byte_done = rise & (cnt_q == BIT_LAST);

   ////////////////////////////////////////////////////////////////////
   // status and protection decode
   // bit layout
   always_comb
   begin
      status = 8'h00;
      status[SR_LOCK] = lock_q;
      status[SR_BPHI] = bphi_q;
      status[SR_BPLO] = bplo_q;
      status[SR_WEL] = wel_q;
   end
   assign protection_status_out = status;
   assign sr_blocked = lock_q & ~lvl_q[PIN_WP];
   assign cur_guarded = fsp_guarded(addr_q, {bphi_q, bplo_q});
   assign shifting = (state_q == ST_SRD) | (state_q == ST_RDATA);

   ////////////////////////////////////////////////////////////////////
   // command sequencer
   always_comb
   begin
      state_d = state_q;
      op_d = op_q;
      addr_d = addr_q;
      stop_d = stop_q;
      pend_d = pend_q;
      rd_req_d = 1'b0;
      wel_set = 1'b0;
      sr_load = 1'b0;
      push_req = 1'b0;
      tx_load_sr = 1'b0;
      if (cs_rise)
      begin
         state_d = ST_IDLE;
      end
      else if (cs_fall)
      begin
         state_d = ST_OPC;
         stop_d = 1'b0;
         pend_d = 1'b0;
      end
      else if (byte_done)
      begin
         case (state_q)
            ST_OPC:
            begin
               op_d = rx;
               case (rx)
                  OP_SET_LATCH:
                  begin
                     wel_set = 1'b1;
                     state_d = ST_DONE;
                  end
                  OP_CLR_LATCH:
                  begin
                     pend_d = 1'b1;
                     state_d = ST_DONE;
                  end
                  OP_STAT_RD:
                  begin
                     tx_load_sr = 1'b1;
                     state_d = ST_SRD;
                  end
                  OP_STAT_WR:
                  begin
                     pend_d = 1'b1;
                     state_d = ST_SWR;
                  end
                  OP_MEM_RD: state_d = ST_ADDR_HI;
                  OP_MEM_WR:
                  begin
                     pend_d = 1'b1;
                     state_d = ST_ADDR_HI;
                  end
                  default: state_d = ST_DONE;
               endcase
            end
            ST_ADDR_HI:
            begin
               addr_d[ADDR_W-1:8] = rx[ADDR_HI_W-1:0];
               state_d = ST_ADDR_LO;
            end
            ST_ADDR_LO:
            begin
               addr_d[7:0] = rx;
               rd_req_d = op_q == OP_MEM_RD;
               state_d = (op_q == OP_MEM_RD) ? ST_RDATA : ST_WDATA;
            end
            ST_WDATA:
            begin
               if (stop_q | cur_guarded)
               begin
                  stop_d = 1'b1;
               end
               else if (wel_q)
               begin
                  push_req = 1'b1;
                  addr_d = addr_q + ADDR_ONE;
               end
            end
            ST_RDATA:
            begin
               addr_d = addr_q + ADDR_ONE;
               rd_req_d = 1'b1;
            end
            ST_SRD: tx_load_sr = 1'b1;
            ST_SWR:
            begin
               sr_load = wel_q & ~sr_blocked;
               state_d = ST_DONE;
            end
            default: state_d = state_q;
         endcase
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         state_q <= ST_IDLE;
         op_q <= 8'h00;
         addr_q <= '0;
         stop_q <= 1'b0;
         pend_q <= 1'b0;
         rd_req_q <= 1'b0;
         rd_load_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         op_q <= op_d;
         addr_q <= addr_d;
         stop_q <= stop_d;
         pend_q <= pend_d;
         rd_req_q <= rd_req_d;
         rd_load_q <= rd_req_q;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // bit counter, input shifter, mode capture
   always_ff @(posedge mclk_in)
   begin
      if (rst_in | cs_fall)
      begin
         cnt_q <= 3'h0;
         sh_q <= 8'h00;
      end
      else if (rise)
      begin
         cnt_q <= cnt_q + 3'h1;
         sh_q <= rx;
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         mode3_q <= 1'b0;
         rise_seen_q <= 1'b0;
      end
      else if (cs_fall)
      begin
         mode3_q <= lvl_q[PIN_SCK];
         rise_seen_q <= 1'b0;
      end
      else if (rise)
      begin
         rise_seen_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // write latch and nonvolatile status bits
   // latch cleared at reset; status bits keep their value
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         wel_q <= 1'b0;
      end
      else if (wel_set)
      begin
         wel_q <= 1'b1;
      end
      else if (cs_rise & pend_q)
      begin
         wel_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (sr_load)
      begin
         lock_q <= rx[SR_LOCK];
         bphi_q <= rx[SR_BPHI];
         bplo_q <= rx[SR_BPLO];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // output shifter
   // status byte or array read byte out
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         tx_q <= 8'h00;
         so_q <= 1'b0;
      end
      else if (tx_load_sr)
      begin
         tx_q <= status;
      end
      else if (rd_load_q)
      begin
         tx_q <= rdata_q;
      end
      else if (fall_act & shifting)
      begin
         so_q <= tx_q[7];
         tx_q <= {tx_q[6:0], 1'b0};
      end
   end

   assign so_out = so_q;
   assign so_oe_out = shifting & sel;

   ////////////////////////////////////////////////////////////////////
   // write path through fifo into the array
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         pw_valid_q <= 1'b0;
         pw_q <= '0;
      end
      else if (push_req)
      begin
         pw_valid_q <= 1'b1;
         pw_q <= '{addr: addr_q, data: rx};
      end
      else if (fifo_in_ready)
      begin
         pw_valid_q <= 1'b0;
      end
   end

   fsp_fifo #(
      .W($bits(fsp_wr_s)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_in(mclk_in),
      .rst_in(rst_in),
      .in_valid_in(pw_valid_q),
      .in_data_in(pw_q),
      .in_ready_out(fifo_in_ready),
      .out_valid_out(fifo_valid),
      .out_data_out(fifo_out),
      .out_ready_in(~rd_req_q)
   );

   // read fetch takes the array port; the drain waits that cycle
   assign fifo_pop = fifo_valid & ~rd_req_q;

   always_ff @(posedge mclk_in)
   begin
      if (fifo_pop)
      begin
         arr_q[fifo_out.addr] <= fifo_out.data;
      end
      if (rd_req_q)
      begin
         rdata_q <= arr_q[addr_q];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (rst_in);

   sequence s_set_cmd;
      byte_done && state_q == ST_OPC && rx == OP_SET_LATCH;
   endsequence

   sequence s_end_write;
      cs_rise && pend_q;
   endsequence

   property p_fixed_zero;
      status[0] == 1'b0 && status[6:4] == 3'h0;
   endproperty
   a_fixed_zero: assert property (p_fixed_zero)
      else $error("reserved status bit set");

   property p_latch_set;
      s_set_cmd |=> wel_q;
   endproperty
   a_latch_set: assert property (p_latch_set)
      else $error("set-latch command did not set latch");

   property p_latch_clr;
      s_end_write |=> !wel_q;
   endproperty
   a_latch_clr: assert property (p_latch_clr)
      else $error("latch not cleared at select rise");

   property p_push_ok;
      push_req |-> wel_q && !fsp_guarded(addr_q, {bphi_q, bplo_q});
   endproperty
   a_push_ok: assert property (p_push_ok)
      else $error("array write without latch or in guarded range");

   property p_sr_blocked;
      byte_done && state_q == ST_SWR && sr_blocked
         |=> $stable({lock_q, bphi_q, bplo_q});
   endproperty
   a_sr_blocked: assert property (p_sr_blocked)
      else $error("status written while pin-protected");

   property p_wrap;
      push_req && addr_q == ADDR_LAST |=> addr_q == '0;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("address did not wrap");

   property p_stop;
      byte_done && state_q == ST_WDATA && cur_guarded
         |=> stop_q && $stable(addr_q);
   endproperty
   a_stop: assert property (p_stop)
      else $error("burst did not stop at guarded address");

   property p_float;
      cs_rise |=> !so_oe_out [*3];
   endproperty
   a_float: assert property (p_float)
      else $error("output driven after select rise");

   property p_ignore;
      state_q == ST_DONE |-> !so_oe_out && !push_req && !sr_load;
   endproperty
   a_ignore: assert property (p_ignore)
      else $error("activity in ignore state");

   property p_commit;
      push_req |=> ##[1:20] fifo_pop;
   endproperty
   a_commit: assert property (p_commit)
      else $error("byte not committed to array");
endmodule

// >>> design/fsp_pkg.sv
package fsp_pkg;
   localparam int ADDR_W = 13;
   localparam int DATA_W = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int SYNC_N = 3;
   localparam int PIN_N = 4;
   localparam int PIN_CS = 0;
   localparam int PIN_SCK = 1;
   localparam int PIN_SI = 2;
   localparam int PIN_WP = 3;
   localparam logic [3:0] PIN_RST = 4'h9;
   localparam logic [7:0] OP_SET_LATCH = 8'h06;
   localparam logic [7:0] OP_CLR_LATCH = 8'h04;
   localparam logic [7:0] OP_STAT_RD = 8'h05;
   localparam logic [7:0] OP_STAT_WR = 8'h01;
   localparam logic [7:0] OP_MEM_RD = 8'h03;
   localparam logic [7:0] OP_MEM_WR = 8'h02;
   localparam int SR_LOCK = 7;
   localparam int SR_BPHI = 3;
   localparam int SR_BPLO = 2;
   localparam int SR_WEL = 1;
   localparam int ADDR_HI_W = ADDR_W - 8;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [ADDR_W-1:0] GUARD_QTR = 13'h1800;
   localparam logic [ADDR_W-1:0] GUARD_HALF = 13'h1000;
   localparam logic [ADDR_W-1:0] ADDR_LAST = 13'h1fff;
   localparam logic [ADDR_W-1:0] ADDR_ONE = 13'h0001;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } fsp_wr_s;

   typedef enum logic [3:0] {
      ST_IDLE, ST_OPC, ST_ADDR_HI, ST_ADDR_LO,
      ST_WDATA, ST_RDATA, ST_SRD, ST_SWR, ST_DONE
   } fsp_state_e;

   function automatic logic fsp_guarded(input logic [ADDR_W-1:0] a,
                                        input logic [1:0] bp);
      case (bp)
         2'h0: return 1'b0;
         2'h1: return a >= GUARD_QTR;
         2'h2: return a >= GUARD_HALF;
         default: return 1'b1;
      endcase
   endfunction
endpackage

// >>> tb/fsp_spi_master.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
module fsp_spi_master (
   input wire logic mclk_in,
   input wire logic so_in,
   input wire logic so_oe_in,
   output logic cs_n_out,
   output logic sck_out,
   output logic si_out,
   output logic wp_n_out
);
   logic mode3 = 1'b0;
   logic oe_seen = 1'b0;
   logic so_last = 1'b0;
   logic so_line;
   initial
   begin
      cs_n_out = 1'b1;
      sck_out = 1'b0;
      si_out = 1'b0;
      wp_n_out = 1'b1;
   end
   // released output shows the inverse of its last level
   assign so_line = so_oe_in ? so_in : ~so_last;
   always @(posedge mclk_in)
   begin
      if (so_oe_in)
         so_last <= so_in;
      oe_seen <= !cs_n_out && (oe_seen || so_oe_in);
   end
   task automatic tick(input int n);
      repeat (n) @(negedge mclk_in);
   endtask
   task automatic start(input logic m3);
      sck_out = m3;
      mode3 = m3;
      tick(8);
      cs_n_out = 1'b0;
      tick(8);
   endtask
   task automatic xfer(input logic [7:0] d, output logic [7:0] r);
      for (int i = 7; i >= 0; i--)
      begin
         sck_out = 1'b0;
         si_out = d[i];
         tick(4);
         sck_out = 1'b1;
         tick(4);
         r[i] = so_line;
      end
   endtask
   task automatic stop();
      if (!mode3)
         sck_out = 1'b0;
      tick(8);
      cs_n_out = 1'b1;
      si_out = ~si_out;
      tick(12);
   endtask
endmodule

// >>> tb/fsp_spi_mem_tb.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
module fsp_spi_mem_tb;
   import fsp_pkg::*;
   logic mclk_in = 1'b0;
   logic rst_in = 1'b1;
   logic cs_n, sck, si, wp_n, so, so_oe;
   logic [DATA_W-1:0] status;
   logic [7:0] r;
   logic [7:0] burst[$];
   int error_cnt = 0;
   int num_checks = 0;

   initial
   begin
      forever #12.5 mclk_in = ~mclk_in;
   end

   fsp_spi_mem dut (.mclk_in(mclk_in), .rst_in(rst_in), .cs_n_in(cs_n),
      .sck_in(sck), .si_in(si), .write_guard_pin_n_in(wp_n), .so_out(so),
      .so_oe_out(so_oe), .protection_status_out(status));
   fsp_spi_master m (.mclk_in(mclk_in), .so_in(so), .so_oe_in(so_oe),
      .cs_n_out(cs_n), .sck_out(sck), .si_out(si), .wp_n_out(wp_n));

   ////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic cmd(input logic [7:0] op);
      m.start(1'b0);
      m.xfer(op, r);
      m.stop();
   endtask
   task automatic sr_chk(input logic [7:0] exp);
      m.start(1'b1);
      m.xfer(OP_STAT_RD, r);
      m.xfer(8'h5a, r);
      chk(r, exp);
      m.xfer(8'h5a, r);
      chk(r, exp);
      chk(status, exp);
      m.stop();
   endtask
   // spare byte after the data byte must be ignored
   task automatic sw(input logic lat, input logic [7:0] v);
      if (lat)
         cmd(OP_SET_LATCH);
      m.start(1'b0);
      m.xfer(OP_STAT_WR, r);
      m.xfer(v, r);
      m.xfer(~v, r);
      m.stop();
   endtask
   task automatic mem(input logic m3, input logic [7:0] op,
                      input logic [12:0] a, input logic [7:0] d[$]);
      m.start(m3);
      m.xfer(op, r);
      m.xfer({3'h7, a[12:8]}, r);
      m.xfer(a[7:0], r);
      foreach (d[i])
      begin
         m.xfer(op == OP_MEM_RD ? 8'ha5 : d[i], r);
         if (op == OP_MEM_RD)
            chk(r, d[i]);
      end
      m.stop();
      chk({7'h0, so_oe}, 8'h00);
   endtask
   task automatic wr(input logic lat, input logic [12:0] a,
                     input logic [7:0] d[$]);
      if (lat)
         cmd(OP_SET_LATCH);
      mem(1'b0, OP_MEM_WR, a, d);
   endtask
   task automatic rd(input logic [12:0] a, input logic [7:0] d[$]);
      mem(1'b1, OP_MEM_RD, a, d);
   endtask
   ////////////////////////////////////////////////////////////////////
   initial
   begin
      #2000000;
      error_cnt++;
      close_out();
   end

   initial
   begin
      repeat (5) @(negedge mclk_in);
      rst_in = 1'b0;
      m.tick(6);
      for (int i = 0; i < FIFO_DEPTH + 2; i++)
      begin
         burst.push_back(8'h30 + 8'(i));
      end
      sr_chk(8'h00);
      cmd(OP_SET_LATCH);
      sr_chk(8'h02);
      cmd(OP_CLR_LATCH);
      sr_chk(8'h00);
      wr(1'b1, 13'h0fff, {8'hc1, 8'hc2});
      wr(1'b1, 13'h17ff, {8'hd1, 8'hd2});
      wr(1'b1, 13'h1fff, {8'he1, 8'he2, 8'he3});
      sr_chk(8'h00);
      rd(13'h0fff, {8'hc1, 8'hc2});
      rd(13'h17ff, {8'hd1, 8'hd2});
      rd(13'h1fff, {8'he1, 8'he2, 8'he3});
      wr(1'b0, 13'h0fff, {8'hf0});
      rd(13'h0fff, {8'hc1});
      // long burst through the write queue, mode 3 write, mode 0 read
      cmd(OP_SET_LATCH);
      mem(1'b1, OP_MEM_WR, 13'h0100, burst);
      chk(status, 8'h00);
      mem(1'b0, OP_MEM_RD, 13'h0100, burst);
      chk(status, 8'h00);
      sw(1'b1, 8'h76);
      sr_chk(8'h04);
      wr(1'b1, 13'h17ff, {8'ha1, 8'ha2, 8'ha3});
      rd(13'h17ff, {8'ha1, 8'hd2});
      sw(1'b1, 8'h08);
      wr(1'b1, 13'h0fff, {8'hb1, 8'hb2});
      rd(13'h0fff, {8'hb1, 8'hc2});
      sw(1'b1, 8'h8c);
      wr(1'b1, 13'h0000, {8'h99});
      rd(13'h1fff, {8'he1, 8'he2});
      m.wp_n_out = 1'b0;
      sw(1'b1, 8'h00);
      sr_chk(8'h8c);
      m.wp_n_out = 1'b1;
      sw(1'b1, 8'h80);
      m.wp_n_out = 1'b0;
      wr(1'b1, 13'h0fff, {8'h77});
      rd(13'h0fff, {8'h77});
      m.wp_n_out = 1'b1;
      sw(1'b1, 8'h04);
      m.wp_n_out = 1'b0;
      sw(1'b1, 8'h08);
      sr_chk(8'h08);
      m.wp_n_out = 1'b1;
      sw(1'b0, 8'h04);
      sr_chk(8'h08);
      cmd(OP_SET_LATCH);
      chk(status, 8'h0a);
      rst_in = 1'b1;
      m.tick(5);
      rst_in = 1'b0;
      m.tick(6);
      chk(status, 8'h08);
      sr_chk(8'h08);
      m.start(1'b0);
      m.xfer(8'h07, r);
      m.xfer(OP_SET_LATCH, r);
      chk(status, 8'h08);
      chk({7'h0, m.oe_seen}, 8'h00);
      m.stop();
      sr_chk(8'h08);
      close_out();
   end
endmodule
